// >>> hw/ssep_pkg.sv
// Shared constants and types for the serial EEPROM command port.
// Assumes a single 10 MHz reference clock; all pins are synchronous to it.
package ssep_pkg;

    localparam int unsigned SSEP_REF_CLK_MHZ      = 10;
    localparam int unsigned SSEP_MIN_DESELECT_NS  = 250;
    localparam int unsigned SSEP_MIN_DESELECT_CYC =
        (SSEP_MIN_DESELECT_NS * SSEP_REF_CLK_MHZ + 999) / 1000;
    localparam int unsigned SSEP_SELF_TIMED_US    = 5000;
    localparam int unsigned SSEP_SELF_TIMED_CYC   = SSEP_SELF_TIMED_US * SSEP_REF_CLK_MHZ;

    localparam int unsigned SSEP_ARRAY_WORDS  = 1024;
    localparam int unsigned SSEP_FIFO_DEPTH   = 8;
    localparam logic [4:0]  SSEP_CMD_BITS_X16  = 5'hC;
    localparam logic [4:0]  SSEP_CMD_BITS_X8   = 5'hD;
    localparam logic [4:0]  SSEP_DATA_BITS_X16 = 5'h10;
    localparam logic [4:0]  SSEP_DATA_BITS_X8  = 5'h8;
    localparam logic [15:0] SSEP_ERASED_WORD   = 16'hFFFF;
    localparam logic [15:0] SSEP_LOW_LANE      = 16'h00FF;
    localparam logic [15:0] SSEP_HIGH_LANE     = 16'hFF00;

    typedef enum logic [1:0] {
        SSEP_OP_EXT   = 2'b00,
        SSEP_OP_WRITE = 2'b01,
        SSEP_OP_READ  = 2'b10,
        SSEP_OP_ERASE = 2'b11
    } ssep_opcode_e;

    typedef enum logic [1:0] {
        SSEP_EXT_LOCK   = 2'b00,
        SSEP_EXT_FILL   = 2'b01,
        SSEP_EXT_CLEAR  = 2'b10,
        SSEP_EXT_UNLOCK = 2'b11
    } ssep_ext_e;

    typedef enum logic [1:0] {
        SSEP_PRG_WRITE     = 2'b00,
        SSEP_PRG_ERASE     = 2'b01,
        SSEP_PRG_CLEAR_ALL = 2'b10,
        SSEP_PRG_FILL_ALL  = 2'b11
    } ssep_prog_op_e;

    typedef enum logic [2:0] {
        SSEP_ST_IDLE = 3'b000,
        SSEP_ST_CMD  = 3'b001,
        SSEP_ST_DATA = 3'b010,
        SSEP_ST_READ = 3'b011,
        SSEP_ST_DONE = 3'b100
    } ssep_state_e;

    typedef struct packed {
        ssep_prog_op_e op;
        logic          x16;
        logic [10:0]   addr;
        logic [15:0]   data;
    } ssep_prog_s;

endpackage

// >>> hw/ssep_command_port.sv
// Serial EEPROM command port: frame decode, sequential read, self-timed programming.
// Assumes cs, sk and di are synchronous to ref_clk and sk is far slower than ref_clk.
// Summary of operation
// - A frame is a one start bit, opcode, address, then data for write types.
// - Instructions are 13 bits in x16 and 14 bits in x8, data excluded.
// - Opcode 10 reads, 11 erases, 01 writes the addressed word.
// - Opcode 00 with top address bits 11 unlock, 00 lock, 10 clear, 01 fill.
// - Input bits are taken on each rising serial clock edge.
// - Data output floats except for read data or busy status.
// - Selected during programming, output is low while busy, high when ready.
// - A one shifted in ends status; output floats at the next falling clock.
// - A read sends one zero bit, then the word most significant bit first.
// - Read output bits change on rising serial clock edges.
// - Sequential read advances and wraps to zero; only first word has zero bit.
// - Select low after write starts a self-timed cycle of at most 5 ms.
// - A write clears the location before storing, no erase needed.
// - Erase clears the addressed location to all ones on select falling.
// - Clear-all sets every array bit to one on select falling.
// - Write-enable latch clears at power-up, set by unlock, cleared by lock.
// - With latch clear, write, erase, clear-all and fill-all are refused.
// - Reads work whatever the write-enable latch holds.
// - Programming needs the permit pin high; unlock and lock ignore it.
// - Array is 16384 bits: 1024 x16 words or 2048 x8 words.
// - Width select high gives x16 words, low gives x8 words.
// - Fill-all writes its word everywhere on select falling, no prior clear.
`timescale 1ns/1ns
`default_nettype none

module ssep_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;

    assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = store[rd_ptr[AW-1:0]];

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (clr) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
        end else begin
            if (in_valid && in_ready) begin
                next_wr_ptr = wr_ptr + {{AW{1'b0}}, 1'b1};
            end
            if (out_valid && out_ready) begin
                next_rd_ptr = rd_ptr + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready && !clr) begin
            store[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule // ssep_fifo

module ssep_command_port
    import ssep_pkg::*;
#(
    parameter int unsigned SELF_TIMED_CYCLES = SSEP_SELF_TIMED_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic cs,
    input  wire logic sk,
    input  wire logic di,
    input  wire logic word_width_select,
    input  wire logic program_permit_pin,
    output logic      do_out,
    output logic      do_oe,
    output logic      prog_busy,
    output logic      write_enable_latch
);
    function automatic logic [9:0] word_index(input logic [10:0] a, input logic x16);
        word_index = x16 ? a[9:0] : a[10:1];
    endfunction

    logic [15:0]  mem [SSEP_ARRAY_WORDS];

    ssep_state_e  state, next_state;
    logic         sk_q, next_sk_q;
    logic         cs_q, next_cs_q;
    logic [1:0]   desel_cnt, next_desel_cnt;
    logic         armed, next_armed;
    logic [12:0]  cmd_sr, next_cmd_sr;
    logic [4:0]   bit_cnt, next_bit_cnt;
    logic         frame_x16, next_frame_x16;
    ssep_prog_s   pend, next_pend;
    logic         pend_valid, next_pend_valid;
    logic         next_wel;
    logic         status_en, next_status_en;
    logic         hz_pending, next_hz_pending;
    logic         next_do_out, next_do_oe;
    logic [10:0]  rd_ptr, next_rd_ptr;
    logic         rd_active, next_rd_active;
    logic [15:0]  out_sr, next_out_sr;
    logic [4:0]   out_cnt, next_out_cnt;
    ssep_prog_s   prog, next_prog;
    logic         next_busy;
    logic [15:0]  prog_cnt, next_prog_cnt;

    logic         sel, sk_rise, sk_fall, cs_fall, start_prog;
    logic [12:0]  shifted;
    logic [4:0]   cmd_len;
    ssep_opcode_e opc;
    ssep_ext_e    ext;
    logic [10:0]  addr_in;
    logic [15:0]  push_data, pop_data, rd_word;
    logic         push_ready, pop_valid, pop_ready;
    logic         mem_we;
    logic [9:0]   mem_addr;
    logic [15:0]  mem_wdata, mem_mask;

    // A new frame is only honoured once select has been low for the minimum deselect time.
    assign sel     = cs && armed;
    assign sk_rise = sk && !sk_q;
    assign sk_fall = !sk && sk_q;
    assign cs_fall = cs_q && !cs;
    assign start_prog = cs_fall && pend_valid && !prog_busy
                        && write_enable_latch && program_permit_pin;

    assign shifted = {cmd_sr[11:0], di};
    assign cmd_len = frame_x16 ? SSEP_CMD_BITS_X16 : SSEP_CMD_BITS_X8;
    assign opc     = ssep_opcode_e'(frame_x16 ? shifted[11:10] : shifted[12:11]);
    assign ext     = ssep_ext_e'(frame_x16 ? shifted[9:8] : shifted[10:9]);
    assign addr_in = frame_x16 ? {1'b0, shifted[9:0]} : shifted[10:0];

    assign rd_word   = mem[word_index(rd_ptr, frame_x16)];
    assign push_data = frame_x16 ? rd_word
                     : {(rd_ptr[0] ? rd_word[15:8] : rd_word[7:0]), 8'h00};
    assign pop_ready = sel && (state == SSEP_ST_READ) && sk_rise && (out_cnt == 5'h0);

    // Prefetched read words wait here, so the serializer never sees array latency.
    ssep_fifo #(.WIDTH(16), .DEPTH(SSEP_FIFO_DEPTH)) u_read_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .clr       (state != SSEP_ST_READ),
        .in_valid  (rd_active),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    always_comb begin
        next_state      = state;
        next_sk_q       = sk;
        next_cs_q       = cs;
        next_desel_cnt  = desel_cnt;
        next_armed      = armed;
        next_cmd_sr     = cmd_sr;
        next_bit_cnt    = bit_cnt;
        next_frame_x16  = frame_x16;
        next_pend       = pend;
        next_pend_valid = pend_valid;
        next_wel        = write_enable_latch;
        next_status_en  = status_en;
        next_hz_pending = hz_pending;
        next_do_out     = do_out;
        next_rd_ptr     = rd_ptr;
        next_rd_active  = rd_active;
        next_out_sr     = out_sr;
        next_out_cnt    = out_cnt;

        if (cs) begin
            next_desel_cnt = 2'h0;
        end else begin
            if (desel_cnt != 2'(SSEP_MIN_DESELECT_CYC)) begin
                next_desel_cnt = desel_cnt + 2'h1;
            end else begin
                next_armed = 1'b1;
            end
        end
        if (cs_fall) begin
            next_armed      = 1'b0;
            next_pend_valid = 1'b0;
        end
        if (start_prog) begin
            next_status_en = 1'b1;
        end

        if (rd_active && push_ready) begin
            next_rd_ptr = frame_x16 ? {1'b0, rd_ptr[9:0] + 10'h1} : rd_ptr + 11'h1;
        end

        if (!sel) begin
            next_state      = SSEP_ST_IDLE;
            next_rd_active  = 1'b0;
            next_hz_pending = 1'b0;
        end else begin
            if (hz_pending && sk_fall) begin
                next_status_en  = 1'b0;
                next_hz_pending = 1'b0;
            end
            case (state)
                SSEP_ST_IDLE: begin
                    if (sk_rise && di) begin
                        next_state      = SSEP_ST_CMD;
                        next_bit_cnt    = 5'h0;
                        next_cmd_sr     = 13'h0;
                        next_frame_x16  = word_width_select;
                        next_hz_pending = status_en;
                    end
                end
                SSEP_ST_CMD: begin
                    if (sk_rise) begin
                        next_cmd_sr  = shifted;
                        next_bit_cnt = bit_cnt + 5'h1;
                        if (bit_cnt + 5'h1 == cmd_len) begin
                            next_bit_cnt = 5'h0;
                            next_state   = SSEP_ST_DONE;
                            next_pend    = '{op: SSEP_PRG_ERASE, x16: frame_x16,
                                             addr: addr_in, data: SSEP_ERASED_WORD};
                            case (opc)
                                SSEP_OP_READ: begin
                                    next_state     = SSEP_ST_READ;
                                    next_rd_ptr    = addr_in;
                                    next_rd_active = 1'b1;
                                    next_do_out    = 1'b0;
                                    next_out_cnt   = 5'h0;
                                end
                                SSEP_OP_ERASE: begin
                                    next_pend_valid = 1'b1;
                                end
                                SSEP_OP_WRITE: begin
                                    next_pend.op = SSEP_PRG_WRITE;
                                    next_state   = SSEP_ST_DATA;
                                end
                                default: begin
                                    case (ext)
                                        SSEP_EXT_UNLOCK: next_wel = 1'b1;
                                        SSEP_EXT_LOCK:   next_wel = 1'b0;
                                        SSEP_EXT_CLEAR: begin
                                            next_pend.op    = SSEP_PRG_CLEAR_ALL;
                                            next_pend_valid = 1'b1;
                                        end
                                        default: begin
                                            next_pend.op = SSEP_PRG_FILL_ALL;
                                            next_state   = SSEP_ST_DATA;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                SSEP_ST_DATA: begin
                    if (sk_rise) begin
                        next_pend.data = {pend.data[14:0], di};
                        next_bit_cnt   = bit_cnt + 5'h1;
                        if (bit_cnt + 5'h1 == (frame_x16 ? SSEP_DATA_BITS_X16
                                                          : SSEP_DATA_BITS_X8)) begin
                            next_pend_valid = 1'b1;
                            next_state      = SSEP_ST_DONE;
                        end
                    end
                end
                SSEP_ST_READ: begin
                    if (sk_rise) begin
                        if (out_cnt == 5'h0) begin
                            // Only the first word follows the zero bit; later words abut.
                            next_do_out  = pop_data[15];
                            next_out_sr  = {pop_data[14:0], 1'b0};
                            next_out_cnt = (frame_x16 ? SSEP_DATA_BITS_X16
                                                      : SSEP_DATA_BITS_X8) - 5'h1;
                        end else begin
                            next_do_out  = out_sr[15];
                            next_out_sr  = {out_sr[14:0], 1'b0};
                            next_out_cnt = out_cnt - 5'h1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (next_state != SSEP_ST_READ) begin
            next_do_out = !next_busy;
        end
        next_do_oe = sel && ((next_state == SSEP_ST_READ) || next_status_en);
    end

    // Programming engine: one array word per cycle for the whole-array forms, then idle
    // until the self-timed cycle expires. The busy window does not depend on the sk pin.
    always_comb begin
        next_prog     = prog;
        next_busy     = prog_busy;
        next_prog_cnt = prog_cnt;
        if (start_prog) begin
            next_prog     = pend;
            next_busy     = 1'b1;
            next_prog_cnt = 16'h0;
        end else if (prog_busy) begin
            next_prog_cnt = prog_cnt + 16'h1;
            if (prog_cnt == 16'(SELF_TIMED_CYCLES - 1)) begin
                next_busy = 1'b0;
            end
        end

        mem_addr  = word_index(prog.addr, prog.x16);
        mem_wdata = prog.x16 ? prog.data : {prog.data[7:0], prog.data[7:0]};
        mem_mask  = SSEP_ERASED_WORD;
        mem_we    = prog_busy && (prog_cnt == 16'h0);
        case (prog.op)
            SSEP_PRG_WRITE: begin
                // Lane replace models auto-clear then store in one step.
                if (!prog.x16) begin
                    mem_mask = prog.addr[0] ? SSEP_HIGH_LANE : SSEP_LOW_LANE;
                end
            end
            SSEP_PRG_ERASE: begin
                mem_wdata = SSEP_ERASED_WORD;
                if (!prog.x16) begin
                    mem_mask = prog.addr[0] ? SSEP_HIGH_LANE : SSEP_LOW_LANE;
                end
            end
            SSEP_PRG_CLEAR_ALL: begin
                mem_wdata = SSEP_ERASED_WORD;
                mem_addr  = prog_cnt[9:0];
                mem_we    = prog_busy && (prog_cnt < 16'(SSEP_ARRAY_WORDS));
            end
            default: begin
                mem_addr = prog_cnt[9:0];
                mem_we   = prog_busy && (prog_cnt < 16'(SSEP_ARRAY_WORDS));
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_addr] <= (mem[mem_addr] & ~mem_mask) | (mem_wdata & mem_mask);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state              <= SSEP_ST_IDLE;
            sk_q               <= 1'b0;
            cs_q               <= 1'b0;
            desel_cnt          <= 2'h0;
            armed              <= 1'b0;
            cmd_sr             <= 13'h0;
            bit_cnt            <= 5'h0;
            frame_x16          <= 1'b1;
            pend               <= '0;
            pend_valid         <= 1'b0;
            write_enable_latch <= 1'b0;
            status_en          <= 1'b0;
            hz_pending         <= 1'b0;
            do_out             <= 1'b1;
            do_oe              <= 1'b0;
            rd_ptr             <= 11'h0;
            rd_active          <= 1'b0;
            out_sr             <= 16'h0;
            out_cnt            <= 5'h0;
            prog               <= '0;
            prog_busy          <= 1'b0;
            prog_cnt           <= 16'h0;
        end else begin
            state              <= next_state;
            sk_q               <= next_sk_q;
            cs_q               <= next_cs_q;
            desel_cnt          <= next_desel_cnt;
            armed              <= next_armed;
            cmd_sr             <= next_cmd_sr;
            bit_cnt            <= next_bit_cnt;
            frame_x16          <= next_frame_x16;
            pend               <= next_pend;
            pend_valid         <= next_pend_valid;
            write_enable_latch <= next_wel;
            status_en          <= next_status_en;
            hz_pending         <= next_hz_pending;
            do_out             <= next_do_out;
            do_oe              <= next_do_oe;
            rd_ptr             <= next_rd_ptr;
            rd_active          <= next_rd_active;
            out_sr             <= next_out_sr;
            out_cnt            <= next_out_cnt;
            prog               <= next_prog;
            prog_busy          <= next_busy;
            prog_cnt           <= next_prog_cnt;
        end
    end
endmodule // ssep_command_port

`default_nettype wire

// >>> test/ssep_command_port_chk.sv
// Pin-level assertions for the serial EEPROM command port.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module ssep_command_port_chk #(
    parameter int unsigned SELF_TIMED_CYCLES = 1100
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    input wire logic word_width_select,
    input wire logic program_permit_pin,
    input wire logic do_out,
    input wire logic do_oe,
    input wire logic prog_busy,
    input wire logic write_enable_latch
);
    logic [31:0] busy_cnt;
    logic [31:0] next_busy_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    always_comb next_busy_cnt = prog_busy ? busy_cnt + 32'h1 : 32'h0;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) busy_cnt <= 32'h0;
        else busy_cnt <= next_busy_cnt;
    end
    a_oe_needs_select: assert property (!cs && !$past(cs) |-> !do_oe)
        else $error("output enabled while deselected");
    a_busy_needs_latch: assert property ($rose(prog_busy) |-> write_enable_latch)
        else $error("busy started with latch clear");
    a_busy_needs_permit: assert property ($rose(prog_busy) |-> program_permit_pin)
        else $error("busy started without permit");
    a_busy_after_fall: assert property ($rose(prog_busy) |-> !cs && !$past(cs))
        else $error("busy started while selected");
    a_busy_span_end: assert property ($fell(prog_busy) |->
        busy_cnt >= SELF_TIMED_CYCLES - 1 && busy_cnt <= SELF_TIMED_CYCLES + 1)
        else $error("busy length wrong");
    a_busy_span_max: assert property (prog_busy |-> busy_cnt <= SELF_TIMED_CYCLES + 1)
        else $error("busy too long");
    a_latch_by_cmd: assert property ($changed(write_enable_latch) |-> $past(cs))
        else $error("latch changed while deselected");
    a_bit_on_rise: assert property (do_oe && $past(do_oe) && $changed(do_out)
        && !prog_busy && !$past(prog_busy) && !$past(prog_busy, 2) |-> $past(sk) && !$past(sk, 2))
        else $error("output bit changed without clock rise");
    a_oe_off_on_fall: assert property ($fell(do_oe) && $past(cs) |->
        !$past(sk) && $past(sk, 2))
        else $error("output released without clock fall");
    a_oe_rise_selected: assert property ($rose(do_oe) |-> $past(cs))
        else $error("output enabled without selection");
    c_busy_start: cover property ($rose(prog_busy));
    c_status_ready: cover property (do_oe && do_out && $fell(prog_busy));
    c_latch_lock: cover property ($fell(write_enable_latch));
endmodule // ssep_command_port_chk
bind ssep_command_port ssep_command_port_chk #(.SELF_TIMED_CYCLES(SELF_TIMED_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .cs(cs), .sk(sk), .di(di),
    .word_width_select(word_width_select), .program_permit_pin(program_permit_pin),
    .do_out(do_out), .do_oe(do_oe), .prog_busy(prog_busy),
    .write_enable_latch(write_enable_latch));
`default_nettype wire

// >>> test/ssep_host_model.sv
// Host controller model: frames instructions on cs, sk and di.
// Tasks are called at a falling ref_clk edge; sk is high for 3 cycles, then low for at least 6.
`timescale 1ns/1ns
`default_nettype none
module ssep_host_model (
    input  wire logic ref_clk,
    output var logic  cs,
    output var logic  sk,
    output var logic  di
);
    initial begin
        cs = 1'b0;
        sk = 1'b0;
        di = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic pulse(input logic b);
        di = b;
        wait_n(3);
        sk = 1'b1;
        wait_n(3);
        sk = 1'b0;
        wait_n(3);
    endtask
    task automatic send(input logic [31:0] v, input int n);
        cs = 1'b1;
        for (int i = n - 1; i >= 0; i--) pulse(v[i]);
    endtask
    // Released di is inverted so a stale bit cannot pass for a driven one.
    task automatic desel();
        di = ~di;
        cs = 1'b0;
        wait_n(6);
    endtask
endmodule // ssep_host_model
`default_nettype wire

// >>> test/tb_ssep_command_port.sv
// Self-checking bench for the serial EEPROM command port in x16 and x8 modes.
// Drives pins through ssep_host_model at falling ref_clk edges.
`timescale 1ns/1ns
`default_nettype none
module tb_ssep_command_port;
    localparam int unsigned ST = 1100;
    logic ref_clk, rst_b, wws, pe, do_out, do_oe, prog_busy, wel;
    wire logic cs, sk, di;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] rd;
    ssep_host_model host (.ref_clk(ref_clk), .cs(cs), .sk(sk), .di(di));
    ssep_command_port #(.SELF_TIMED_CYCLES(ST)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs(cs), .sk(sk), .di(di),
        .word_width_select(wws), .program_permit_pin(pe), .do_out(do_out),
        .do_oe(do_oe), .prog_busy(prog_busy), .write_enable_latch(wel));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        while (prog_busy === 1'b1 && k < ST + 100) begin
            @(negedge ref_clk);
            k++;
        end
        check("busy end", 16'h0, 16'(prog_busy));
    endtask
    task automatic prog(input logic [31:0] v, input int n, input logic exp);
        host.send(v, n);
        host.desel();
        check("busy start", 16'(exp), 16'(prog_busy));
        wait_ready();
    endtask
    task automatic rd2(input logic [10:0] a, input logic x16);
        host.send(x16 ? {19'h0, 1'b1, 2'b10, a[9:0]} : {18'h0, 1'b1, 2'b10, a}, x16 ? 13 : 14);
        check("dummy oe", 16'h1, 16'(do_oe));
        check("dummy bit", 16'h0, 16'(do_out));
        for (int i = 31; i >= 0; i--) begin
            host.pulse(1'b0);
            rd[i] = do_out;
        end
        host.desel();
    endtask
    task automatic t_reset();
        check("latch", 16'h0, 16'(wel));
        check("oe", 16'h0, 16'(do_oe));
        $display("test reset done");
    endtask
    task automatic t_protect();
        prog({3'h0, 13'h17FF, 16'hA5C3}, 29, 1'b0);
        host.send(32'h1300, 13);
        host.desel();
        check("unlock", 16'h1, 16'(wel));
        pe = 1'b0;
        prog(32'h1200, 13, 1'b0);
        pe = 1'b1;
        $display("test protect done");
    endtask
    task automatic t_program();
        host.send({3'h0, 13'h1100, 16'h1234}, 29);
        host.desel();
        check("fill busy", 16'h1, 16'(prog_busy));
        host.cs = 1'b1;
        host.wait_n(3);
        check("poll oe", 16'h1, 16'(do_oe));
        check("poll busy", 16'h0, 16'(do_out));
        wait_ready();
        host.wait_n(3);
        check("poll ready", 16'h1, 16'(do_out));
        host.pulse(1'b1);
        check("status off", 16'h0, 16'(do_oe));
        host.desel();
        prog({3'h0, 13'h17FF, 16'hA5C3}, 29, 1'b1);
        rd2(11'h3FF, 1'b1);
        check("last word", 16'hA5C3, rd[31:16]);
        check("wrapped word", 16'h1234, rd[15:0]);
        $display("test program done");
    endtask
    task automatic t_x8();
        wws = 1'b0;
        prog({10'h0, 14'h2FFF, 8'h5A}, 22, 1'b1);
        rd2(11'h7FF, 1'b0);
        check("x8 upper", 16'h005A, {8'h00, rd[31:24]});
        check("x8 wrapped", 16'h0034, {8'h00, rd[23:16]});
        check("x8 lower", 16'h0012, {8'h00, rd[15:8]});
        wws = 1'b1;
        $display("test x8 done");
    endtask
    task automatic t_lock();
        prog(32'h1C00, 13, 1'b1);
        rd2(11'h3FF, 1'b1);
        check("erased word", 16'hFFFF, rd[15:0]);
        prog(32'h1200, 13, 1'b1);
        host.send(32'h1000, 13);
        host.desel();
        check("lock", 16'h0, 16'(wel));
        rd2(11'h3FF, 1'b1);
        check("cleared array", 16'hFFFF, rd[31:16]);
        prog(32'h1C00, 13, 1'b0);
        $display("test lock done");
    endtask
    initial begin
        rst_b = 1'b0;
        wws = 1'b1;
        pe = 1'b1;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        host.wait_n(8);
        t_reset();
        t_protect();
        t_program();
        t_x8();
        t_lock();
        close_out();
    end
    // Five busy cycles plus framing need under 10000 cycles.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end
endmodule // tb_ssep_command_port
`default_nettype wire
